// *** rtl/spad_baud_gen.v ***
// baud tick generator: sixteen-times or four-times oversample enable pulses
module spad_baud_gen (
  // clock and reset
  input  wire       core_clk,
  input  wire       resetn,
  // control
  input  wire       enable,
  input  wire [7:0] divisor,
  input  wire       hiBaud,
  // output
  output reg        sampleTick
);

  reg [7:0] divCnt_q;

  // one tick every divisor+1 clocks; sample rate chosen by hiBaud in the receiver
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_q   <= 8'h00;
      sampleTick <= 1'b0;
    end else if (!enable) begin
      divCnt_q   <= 8'h00;
      sampleTick <= 1'b0;
    end else if (divCnt_q == divisor) begin
      divCnt_q   <= 8'h00;
      sampleTick <= 1'b1;
    end else begin
      divCnt_q   <= divCnt_q + 8'h01;
      sampleTick <= 1'b0;
    end
  end

endmodule // spad_baud_gen

// *** rtl/spad_regs.vh ***
// register offsets, field positions and reset values for the address-detect serial port
`ifndef SPAD_REGS_VH
`define SPAD_REGS_VH

// register byte offsets on the apb bus
`define SPAD_TXSC_OFF        12'h000
`define SPAD_RXSC_OFF        12'h004
`define SPAD_RXBUF_OFF       12'h008
`define SPAD_BAUD_OFF        12'h00C
`define SPAD_IRQ_OFF         12'h010
`define SPAD_TXBUF_OFF       12'h014

// transmit status and control fields
`define SPAD_TX_CLKSRC_BIT   7
`define SPAD_TX_NINE_BIT     6
`define SPAD_TX_EN_BIT       5
`define SPAD_TX_SYNC_BIT     4
`define SPAD_TX_HIBAUD_BIT   2
`define SPAD_TX_EMPTY_BIT    1
`define SPAD_TX_D9_BIT       0
`define SPAD_TXSC_WMASK      8'hF5
`define SPAD_TXSC_RESET      8'h02

// receive status and control fields
`define SPAD_RX_PORTEN_BIT   7
`define SPAD_RX_NINE_BIT     6
`define SPAD_RX_CONT_BIT     4
`define SPAD_RX_ADDR_BIT     3
`define SPAD_RX_FERR_BIT     2
`define SPAD_RX_OVERRUN_ERROR_FLAG_BIT     1
`define SPAD_RX_D9_BIT       0
`define SPAD_RXSC_RESET      8'h00

// interrupt control register fields
`define SPAD_IRQ_RXIE_BIT    0
`define SPAD_IRQ_PERIPHERAL_IRQ_ENABLE_BIT    1
`define SPAD_IRQ_GIE_BIT     2
`define SPAD_IRQ_RXF_BIT     3

// baud divisor reset
`define SPAD_BAUD_RESET      8'h00

`endif

// *** rtl/spad_rx_shift.v ***
// receive shifter: start detect, mid-bit sampling, 8 or 9 data bits, stop check
module spad_rx_shift (
  // clock and reset
  input  wire       core_clk,
  input  wire       resetn,
  // control
  input  wire       enable,
  input  wire       nineBit,
  input  wire       hiBaud,
  input  wire       sampleTick,
  input  wire       rxPin,
  // character out
  output reg        charDone,
  output reg  [8:0] charData,
  output reg        charFrameErr
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_START = 4'b0010;
  localparam [3:0] ST_DATA  = 4'b0100;
  localparam [3:0] ST_STOP  = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] phase_q;
  reg [3:0] bitCnt_q;
  reg [8:0] shift_q;
  wire [3:0] lastPhase = hiBaud ? 4'h3 : 4'hF;
  wire [3:0] midPhase  = hiBaud ? 4'h1 : 4'h7;
  wire [3:0] numBits   = nineBit ? 4'h9 : 4'h8;

  // oversampled frame walk, lsb first
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      phase_q      <= 4'h0;
      bitCnt_q     <= 4'h0;
      shift_q      <= 9'h000;
      charDone     <= 1'b0;
      charData     <= 9'h000;
      charFrameErr <= 1'b0;
    end else begin
      charDone <= 1'b0;
      if (!enable) begin
        state_q <= ST_IDLE;
      end else if (sampleTick) begin
        case (state_q)
          ST_IDLE: begin
            phase_q <= 4'h0;
            if (!rxPin) state_q <= ST_START;
          end
          ST_START: begin
            phase_q <= phase_q + 4'h1;
            if (phase_q == midPhase) begin
              // a glitch shorter than half a bit is not a start
              if (rxPin) state_q <= ST_IDLE;
              else begin
                state_q  <= ST_DATA;
                phase_q  <= 4'h0;
                bitCnt_q <= 4'h0;
              end
            end
          end
          ST_DATA: begin
            phase_q <= (phase_q == lastPhase) ? 4'h0 : phase_q + 4'h1;
            if (phase_q == lastPhase) begin
              shift_q  <= nineBit ? {rxPin, shift_q[8:1]} : {1'b0, rxPin, shift_q[7:1]};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == numBits - 4'h1) state_q <= ST_STOP;
            end
          end
          ST_STOP: begin
            phase_q <= (phase_q == lastPhase) ? 4'h0 : phase_q + 4'h1;
            if (phase_q == lastPhase) begin
              charDone     <= 1'b1;
              charData     <= shift_q;
              charFrameErr <= ~rxPin;
              state_q      <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // spad_rx_shift

// *** rtl/spad_serial_port.v ***
// serial port with 9-bit address detection receiver, transmit control and apb registers
// What this block does
// - address detection acts only while address_detect_enable is set
// - in address mode with 9-bit reception, keep only ninth-bit-set characters
// - without address detection every character reaches the buffer and flags, except one that arrives while the buffer is still full
// - baud rate comes from baud_divisor and high_baud_select
// - port runs only with serial_port_enable set and clocked mode clear
// - nine_bit_receive makes the receiver capture a ninth data bit
// - characters are accepted only while continuous_receive_enable is set
// - receive_flag sets when a character moves into the buffer
// - receive interrupt needs receive, peripheral and global enables
// - status read returns error flags and head character's ninth bit
// - in address mode the reported ninth bit reads as one
// - buffer read returns the low eight data bits
// - overrun flag holds until continuous_receive_enable is cleared
// - clock_source_select is bit 7, ignored in asynchronous mode
// - transmit_ninth_bit supplies the ninth transmitted bit
`include "spad_regs.vh"
module spad_serial_port (
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // serial line
  input  wire        rxPin,
  output reg         txPin,
  // interrupt request
  output reg         rxIrq
);

  // control and status state
  reg  [7:0] txsc_q;
  reg  [7:0] rxsc_q;
  reg  [7:0] baud_q;
  reg  [2:0] irqEn_q;
  reg        rxFlag_q;
  reg        overrun_error_flag_q;
  reg        ferr_q;
  reg  [8:0] rxBuf_q;
  reg        txBusy_q;
  reg  [10:0] txShift_q;
  reg  [3:0] txBits_q;
  reg  [3:0] txPhase_q;

  wire       sampleTick;
  wire       charDone;
  wire [8:0] charData;
  wire       charFrameErr;

  // write and read strobes taken in the access phase
  wire apbWr = psel & penable & pwrite & pready;
  wire apbRd = psel & penable & ~pwrite & pready;

  // decode: true when address hits a given register offset
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire mapped = hit(paddr, `SPAD_TXSC_OFF) | hit(paddr, `SPAD_RXSC_OFF) |
                hit(paddr, `SPAD_RXBUF_OFF) | hit(paddr, `SPAD_BAUD_OFF) |
                hit(paddr, `SPAD_IRQ_OFF) | hit(paddr, `SPAD_TXBUF_OFF);

  // port runs only enabled and asynchronous
  wire portOn  = rxsc_q[`SPAD_RX_PORTEN_BIT] & ~txsc_q[`SPAD_TX_SYNC_BIT];
  wire rxOn    = portOn & rxsc_q[`SPAD_RX_CONT_BIT];
  wire addrMode = rxsc_q[`SPAD_RX_ADDR_BIT] & rxsc_q[`SPAD_RX_NINE_BIT];
  // clock_source_select is stored but has no effect in asynchronous mode

  spad_baud_gen u_baud (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .enable     (portOn),
    .divisor    (baud_q),
    .hiBaud     (txsc_q[`SPAD_TX_HIBAUD_BIT]),
    .sampleTick (sampleTick)
  );

  spad_rx_shift u_rx (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .enable       (rxOn),
    .nineBit      (rxsc_q[`SPAD_RX_NINE_BIT]),
    .hiBaud       (txsc_q[`SPAD_TX_HIBAUD_BIT]),
    .sampleTick   (sampleTick),
    .rxPin        (rxPin),
    .charDone     (charDone),
    .charData     (charData),
    .charFrameErr (charFrameErr)
  );

  // address mode drops characters whose ninth bit is zero
  wire keepChar = charDone & (~addrMode | charData[8]);
  wire bufRead  = apbRd & hit(paddr, `SPAD_RXBUF_OFF);

  // one-character buffer, flag and error tracking
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxFlag_q <= 1'b0;
      overrun_error_flag_q   <= 1'b0;
      ferr_q   <= 1'b0;
      rxBuf_q  <= 9'h000;
    end else begin
      if (keepChar && rxFlag_q && !bufRead) begin
        overrun_error_flag_q <= 1'b1; // full buffer: new character lost
      end else if (keepChar) begin
        rxBuf_q  <= charData;
        ferr_q   <= charFrameErr;
        rxFlag_q <= 1'b1; // set wins over the read-clear
      end else if (bufRead) begin
        rxFlag_q <= 1'b0;
      end
      if (!rxsc_q[`SPAD_RX_CONT_BIT]) overrun_error_flag_q <= 1'b0;
    end
  end

  // transmit: write to the transmit buffer loads the shifter directly
  wire txLoad = apbWr & hit(paddr, `SPAD_TXBUF_OFF) & ~txBusy_q &
                portOn & txsc_q[`SPAD_TX_EN_BIT];
  wire [3:0] txLastPhase = txsc_q[`SPAD_TX_HIBAUD_BIT] ? 4'h3 : 4'hF;
  wire [3:0] txFrameBits = txsc_q[`SPAD_TX_NINE_BIT] ? 4'hB : 4'hA;

  // frame shifter: start, data lsb first, optional ninth bit, stop
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txBusy_q  <= 1'b0;
      txShift_q <= 11'h7FF;
      txBits_q  <= 4'h0;
      txPhase_q <= 4'h0;
      txPin     <= 1'b1;
    end else if (txLoad) begin
      txBusy_q  <= 1'b1;
      txPhase_q <= 4'h0;
      txBits_q  <= 4'h0;
      txShift_q <= txsc_q[`SPAD_TX_NINE_BIT] ?
                   {1'b1, txsc_q[`SPAD_TX_D9_BIT], pwdata[7:0], 1'b0} :
                   {2'b11, pwdata[7:0], 1'b0};
    end else if (!portOn) begin
      txBusy_q <= 1'b0;
      txPin    <= 1'b1;
    end else if (txBusy_q && sampleTick) begin
      txPin <= txShift_q[0];
      if (txPhase_q == txLastPhase) begin
        txPhase_q <= 4'h0;
        txShift_q <= {1'b1, txShift_q[10:1]};
        txBits_q  <= txBits_q + 4'h1;
        if (txBits_q == txFrameBits - 4'h1) txBusy_q <= 1'b0;
      end else begin
        txPhase_q <= txPhase_q + 4'h1;
      end
    end else if (!txBusy_q) begin
      txPin <= 1'b1;
    end
  end

  // software writes to control registers
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txsc_q  <= `SPAD_TXSC_RESET;
      rxsc_q  <= `SPAD_RXSC_RESET;
      baud_q  <= `SPAD_BAUD_RESET;
      irqEn_q <= 3'b000;
    end else if (apbWr) begin
      if (hit(paddr, `SPAD_TXSC_OFF)) txsc_q <= pwdata[7:0] & `SPAD_TXSC_WMASK;
      if (hit(paddr, `SPAD_RXSC_OFF)) rxsc_q <= {pwdata[7:6], 1'b0, pwdata[4:3], 3'b000};
      if (hit(paddr, `SPAD_BAUD_OFF)) baud_q <= pwdata[7:0];
      if (hit(paddr, `SPAD_IRQ_OFF))  irqEn_q <= pwdata[2:0];
    end
  end

  // status bytes as software sees them
  wire [7:0] txscRead = {txsc_q[7:2], ~txBusy_q, txsc_q[0]};
  wire       d9Read   = addrMode ? 1'b1 : (rxsc_q[`SPAD_RX_NINE_BIT] & rxBuf_q[8]);
  wire [7:0] rxscRead = {rxsc_q[7:3], ferr_q, overrun_error_flag_q, d9Read};

  // apb answer: zero wait states, error on unmapped address
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, `SPAD_TXSC_OFF))  prdata <= {24'h00_0000, txscRead};
        if (hit(paddr, `SPAD_RXSC_OFF))  prdata <= {24'h00_0000, rxscRead};
        if (hit(paddr, `SPAD_RXBUF_OFF)) prdata <= {24'h00_0000, rxBuf_q[7:0]};
        if (hit(paddr, `SPAD_BAUD_OFF))  prdata <= {24'h00_0000, baud_q};
        if (hit(paddr, `SPAD_IRQ_OFF))   prdata <= {28'h000_0000, rxFlag_q, irqEn_q};
      end
    end
  end

  // interrupt request gated by all three enables
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) rxIrq <= 1'b0;
    else         rxIrq <= rxFlag_q & (&irqEn_q);
  end

endmodule // spad_serial_port

// *** verif/serial_port_address_detect_rx_tb.sv ***
// self-checking bench for the address-detect serial port
`include "spad_regs.vh"
module serial_port_address_detect_rx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, resetn, psel, penable, pwrite;
  logic        rxPin, txPin, rxIrq, pready, pslverr, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int          err_total, n_tests;

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  spad_serial_port dut_u (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxPin(rxPin), .txPin(txPin), .rxIrq(rxIrq));
  spad_node_model node_u (.core_clk(core_clk), .rxLine(rxPin));

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests++;
      if (g !== e) begin
        err_total++;
        $display("FAIL %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
        err_total++;
        end_sim();
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rdv);
    end
  endtask
  // send a nine-bit frame at the fast bit time of eight clocks
  task snd(input logic [8:0] v);
    node_u.send(v, 1'b1, 8);
  endtask

  task t_regs;
    begin
      rdc(`SPAD_TXSC_OFF, 32'h0000_0002, "txsc rst");
      rdc(`SPAD_RXSC_OFF, 32'h0000_0000, "rxsc rst");
      wr(`SPAD_TXSC_OFF, 32'h0000_00FF);
      rdc(`SPAD_TXSC_OFF, 32'h0000_00F7, "txsc rw");
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, erv});
      chk("unmapped", 32'h0000_0000, rdv);
      wr(`SPAD_BAUD_OFF, 32'h0000_0001);
      wr(`SPAD_TXSC_OFF, 32'h0000_0004);
    end
  endtask
  task t_addr;
    begin
      wr(`SPAD_RXSC_OFF, 32'h0000_00D8);
      snd(9'h055);
      rdc(`SPAD_IRQ_OFF, 32'h0000_0000, "drop");
      snd(9'h1A5);
      rdc(`SPAD_IRQ_OFF, 32'h0000_0008, "flag");
      rdc(`SPAD_RXSC_OFF, 32'h0000_00D9, "rxsc addr");
      rdc(`SPAD_RXBUF_OFF, 32'h0000_00A5, "buf addr");
      wr(`SPAD_RXSC_OFF, 32'h0000_00D0);
      snd(9'h03C);
      rdc(`SPAD_RXSC_OFF, 32'h0000_00D0, "rxsc data");
      rdc(`SPAD_RXBUF_OFF, 32'h0000_003C, "buf data");
      wr(`SPAD_RXSC_OFF, 32'h0000_00D8);
      snd(9'h066);
      rdc(`SPAD_IRQ_OFF, 32'h0000_0000, "readdr");
    end
  endtask
  task t_off;
    begin
      wr(`SPAD_RXSC_OFF, 32'h0000_00C0);
      snd(9'h1AA);
      rdc(`SPAD_IRQ_OFF, 32'h0000_0000, "no cont");
      wr(`SPAD_RXSC_OFF, 32'h0000_0050);
      snd(9'h1AA);
      rdc(`SPAD_IRQ_OFF, 32'h0000_0000, "port off");
      wr(`SPAD_TXSC_OFF, 32'h0000_0014);
      wr(`SPAD_RXSC_OFF, 32'h0000_00D0);
      snd(9'h1AA);
      rdc(`SPAD_IRQ_OFF, 32'h0000_0000, "clocked");
      wr(`SPAD_TXSC_OFF, 32'h0000_0004);
    end
  endtask
  // second frame lands while the first is unread
  task t_ovr;
    begin
      snd(9'h011);
      snd(9'h022);
      rdc(`SPAD_RXSC_OFF, 32'h0000_00D2, "ovr set");
      wr(`SPAD_RXSC_OFF, 32'h0000_00D0);
      rdc(`SPAD_RXSC_OFF, 32'h0000_00D2, "ovr hold");
      wr(`SPAD_RXSC_OFF, 32'h0000_00C0);
      rdc(`SPAD_RXSC_OFF, 32'h0000_00C0, "ovr clr");
      rdc(`SPAD_RXBUF_OFF, 32'h0000_0011, "ovr buf");
    end
  endtask
  task t_irq;
    begin
      wr(`SPAD_RXSC_OFF, 32'h0000_00D0);
      wr(`SPAD_IRQ_OFF, 32'h0000_0007);
      snd(9'h1F0);
      chk("irq on", 32'h0000_0001, {31'h0, rxIrq});
      rdc(`SPAD_RXBUF_OFF, 32'h0000_00F0, "irq buf");
      rdc(`SPAD_IRQ_OFF, 32'h0000_0007, "irq clr");
      chk("irq off", 32'h0000_0000, {31'h0, rxIrq});
      wr(`SPAD_IRQ_OFF, 32'h0000_0003);
      snd(9'h0F1);
      chk("no gie", 32'h0000_0000, {31'h0, rxIrq});
      rdc(`SPAD_IRQ_OFF, 32'h0000_000B, "flag only");
      rdc(`SPAD_RXBUF_OFF, 32'h0000_00F1, "buf2");
    end
  endtask
  // slow rate: divisor 0, sixteen clocks per bit
  task t_baud;
    begin
      wr(`SPAD_BAUD_OFF, 32'h0000_0000);
      wr(`SPAD_TXSC_OFF, 32'h0000_0000);
      node_u.send(9'h1C3, 1'b1, 16);
      rdc(`SPAD_RXBUF_OFF, 32'h0000_00C3, "slow");
      // eight-bit frames: address enable alone must not filter anything
      wr(`SPAD_RXSC_OFF, 32'h0000_0098);
      node_u.send(9'h05B, 1'b0, 16);
      rdc(`SPAD_RXBUF_OFF, 32'h0000_005B, "eight");
      rdc(`SPAD_RXSC_OFF, 32'h0000_0098, "rxsc eight");
    end
  endtask
  // nine-bit frame with clock source set: eight clocks a bit, sampled mid-bit
  task t_tx;
    int k;
    logic [10:0] fr;
    begin
      wr(`SPAD_BAUD_OFF, 32'h0000_0001);
      wr(`SPAD_TXSC_OFF, 32'h0000_00E5);
      wr(`SPAD_TXBUF_OFF, 32'h0000_005A);
      rdc(`SPAD_TXSC_OFF, 32'h0000_00E5, "busy");
      for (k = 0; k < 100 && txPin !== 1'b0; k++) @(posedge core_clk);
      chk("tx start", 32'h0000_0000, {31'h0, txPin});
      repeat (3) @(posedge core_clk);
      for (k = 0; k < 11; k++) begin
        fr[k] = txPin;
        repeat (8) @(posedge core_clk);
      end
      chk("tx frame", 32'h0000_06B4, {21'h0, fr});
      rdc(`SPAD_TXSC_OFF, 32'h0000_00E7, "empty");
    end
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    resetn = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_addr();
    t_off();
    t_ovr();
    t_irq();
    t_baud();
    t_tx();
    end_sim();
  end
endmodule // serial_port_address_detect_rx_tb

// *** verif/spad_node_model.sv ***
// remote node model: drives asynchronous frames onto the shared line
module spad_node_model (
  // clock
  input  wire logic core_clk,
  // line
  output logic      rxLine
);
  timeunit 1ns;
  timeprecision 1ns;
  // line idles high between frames
  initial rxLine = 1'b1;
  // start, data lsb first, optional ninth, stop, then idle high to fill fourteen bit times
  task automatic send(input logic [8:0] v, input logic nine, input int bt);
    logic [11:0] fr;
    begin
      fr = nine ? {2'b11, v, 1'b0} : {3'b111, v[7:0], 1'b0};
      for (int i = 0; i < 14 * bt; i++) begin
        @(posedge core_clk);
        rxLine <= (i / bt < 12) ? fr[i / bt] : 1'b1;
      end
    end
  endtask
endmodule // spad_node_model

// *** verif/spad_serial_port_checker.sv ***
// concurrent checks on the bus and pin side of the serial port
`include "spad_regs.vh"
module spad_serial_port_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line and irq
  input wire logic        txPin,
  input wire logic        rxIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // misaligned or past the last register
  wire badAddr = (paddr[1:0] != 2'b00) || (paddr > `SPAD_TXBUF_OFF);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd;
    pready && !pwrite;
  endsequence
  a_ready_once: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("pready without a request");
  a_err_unmapped: assert property (pready && badAddr |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && !badAddr |-> !pslverr)
    else $error("mapped access refused");
  a_upper_zero: assert property (s_rd |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_bad_read_zero: assert property (s_rd and badAddr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_txsc_bit3: assert property (s_rd and paddr == `SPAD_TXSC_OFF |-> !prdata[3])
    else $error("unused control bit reads one");
  a_reset_idle: assert property ($rose(resetn) |-> txPin && !rxIrq && !pready)
    else $error("outputs not idle after reset");
endmodule // spad_serial_port_checker

bind spad_serial_port spad_serial_port_checker chk_u (.core_clk(core_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txPin(txPin), .rxIrq(rxIrq));
